// [asrc_params.svh]
// timing constants and widths for the static memory host controller
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH

`define ASRC_CLK_PERIOD_NS          40
`define ASRC_ADDR_W                 22
`define ASRC_STORE_PULSE_MIN_NS     7
`define ASRC_SELECT_TO_END_NS       7
`define ASRC_ADDR_VALID_TO_END_NS   7
`define ASRC_DATA_LEAD_MIN_NS       5
`define ASRC_DATA_TRAIL_MIN_NS      0
`define ASRC_ADDR_LEAD_MIN_NS       0
`define ASRC_STORE_RECOVERY_MIN_NS  0
`define ASRC_ADDR_TO_OUTPUT_MAX_NS  10
`define ASRC_SELECT_TO_OUTPUT_MAX_NS 10
`define ASRC_GATE_TO_OUTPUT_MAX_NS  5
`define ASRC_DESELECT_TO_FLOAT_MAX_NS 5
`define ASRC_STORE_RELEASE_TO_DRIVE_NS 3

// least times round up to whole cycles, never below one
`define ASRC_CYC_MIN(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS < 1 ? 1 : \
  ((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)

`define ASRC_STORE_CYC  `ASRC_CYC_MIN(`ASRC_STORE_PULSE_MIN_NS)
`define ASRC_SETUP_CYC  `ASRC_CYC_MIN(`ASRC_ADDR_LEAD_MIN_NS)
`define ASRC_TRAIL_CYC  `ASRC_CYC_MIN(`ASRC_STORE_RECOVERY_MIN_NS)
`define ASRC_READ_CYC   `ASRC_CYC_MIN(`ASRC_ADDR_TO_OUTPUT_MAX_NS)
`define ASRC_FLOAT_CYC  `ASRC_CYC_MIN(`ASRC_DESELECT_TO_FLOAT_MAX_NS)

`endif

// [asrc_pkg.sv]
// types shared by the static memory host controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE   = 3'b000,
    ASRC_SETUP  = 3'b001,
    ASRC_STORE  = 3'b011,
    ASRC_TRAIL  = 3'b010,
    ASRC_READ   = 3'b110,
    ASRC_FLOAT  = 3'b111
  } asrc_state_e;
endpackage

// [asrc_phase_timer.sv]
// down-counter that times each phase of a memory access
`timescale 1ns/100ps
`default_nettype none
module asrc_phase_timer #(
  parameter int W = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);
  if (W < 1) begin
    $error("asrc_phase_timer: counter width must be at least one");
  end

  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // done from the count alone: gating it with load would close a loop through
  // the sequencer, which loads on done
  assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

// [asrc_host.sv]
// host controller that sequences a 4M x 1 asynchronous static memory
// How it works
// R1 - memory stores only while select and store strobe are both low
// R2 - store runs from later falling edge to earlier rising edge
// R3 - store strobe low for at least 7 ns
// R4 - address valid no later than select falling
// R5 - strobe or select high whenever the address moves
// R6 - never drive opposing data while memory output drives; gate kept high in writes
// R7 - select falls with the strobe so output stays floating
// R8 - at least 0 ns from address change to store start
// R9 - at least 0 ns from store end to address change
// R10 - select low at least 7 ns before store end
// R11 - address valid at least 7 ns before store end
// R12 - input bit stable 5 ns before store end and 0 ns after
// R13 - read data sampled no earlier than 10 ns after address and select
// R14 - read data sampled no earlier than 5 ns after gate falls
// R15 - memory keeps old output 3 ns after address change
// R16 - memory output leaves float no sooner than 3 ns after select
// R17 - memory floats within 5 ns of select or gate rising
// R18 - memory floats within 5 ns of strobe low, drives 3 ns after rise
// R19 - select high standby, gate low read, strobe low write
`timescale 1ns/100ps
`default_nettype none
`include "asrc_params.svh"
module asrc_host
  import asrc_pkg::*;
#(
  parameter int ADDR_W     = `ASRC_ADDR_W,
  parameter int STORE_CYC  = `ASRC_STORE_CYC,
  parameter int READ_CYC   = `ASRC_READ_CYC,
  parameter int FLOAT_CYC  = `ASRC_FLOAT_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic              req_data_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   rd_data_o,
  output logic [ADDR_W-1:0]      word_address_o,
  output logic                   data_in_o,
  input  wire logic              data_out_i,
  output logic                   select_n_o,
  output logic                   gate_n_o,
  output logic                   store_n_o
);
  localparam int TW = 4;

  // refuse sizes that the counter or the memory's address pins cannot serve
  if (ADDR_W < 1 || ADDR_W > 22) begin
    $error("asrc_host: address width out of range");
  end
  if (STORE_CYC < 1 || STORE_CYC > 15) begin
    $error("asrc_host: store phase count out of range");
  end
  if (READ_CYC < 1 || READ_CYC > 15) begin
    $error("asrc_host: read phase count out of range");
  end
  if (FLOAT_CYC < 1 || FLOAT_CYC > 15) begin
    $error("asrc_host: float phase count out of range");
  end

  asrc_state_e  state_q;
  logic         is_write_q;
  logic         tmr_load;
  logic [TW-1:0] tmr_count;
  logic         tmr_done;
  logic         select_n_d;
  logic         store_n_d;
  logic         gate_n_d;
  logic         done_d;
  logic         busy_d;

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n - 1);
  endfunction

  // a request is only taken in idle; anything asked while busy is dropped
  function automatic logic taking(input asrc_state_e st, input logic req);
    taking = (st == ASRC_IDLE) && req;
  endfunction

  // strobes open on the cycle that the setup gap ends
  function automatic logic opens(input asrc_state_e st, input logic done);
    opens = (st == ASRC_SETUP) && done;
  endfunction

  // strobes stay low while the timed phase still has cycles to run
  function automatic logic holds(input asrc_state_e st, input logic done,
                                 input asrc_state_e phase);
    holds = (st == phase) && !done;
  endfunction

  // the last cycle of an access: recovery after a store, float after a read
  function automatic logic last_cycle(input asrc_state_e st, input logic done);
    last_cycle = ((st == ASRC_TRAIL) || (st == ASRC_FLOAT)) && done;
  endfunction

  asrc_phase_timer #(.W(TW)) asrc_phase_timer_i (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_q)
      ASRC_IDLE: begin
        tmr_load  = req_i;
        tmr_count = cyc(`ASRC_SETUP_CYC);
      end
      ASRC_SETUP: begin
        tmr_load  = tmr_done;
        tmr_count = is_write_q ? cyc(STORE_CYC) : cyc(READ_CYC);
      end
      ASRC_STORE: begin
        tmr_load  = tmr_done;
        tmr_count = cyc(`ASRC_TRAIL_CYC);
      end
      ASRC_READ: begin
        tmr_load  = tmr_done;
        tmr_count = cyc(FLOAT_CYC);
      end
      ASRC_TRAIL: begin
        // recovery gap was loaded as the store ended; let it run out
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
      ASRC_FLOAT: begin
        // float gap was loaded as the read ended; let it run out
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // phase sequencing; address only moves in idle with all strobes high
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q <= ASRC_IDLE;
    end else begin
      case (state_q)
        ASRC_IDLE:  if (req_i) state_q <= ASRC_SETUP; // R8
        ASRC_SETUP: if (tmr_done) state_q <= is_write_q ? ASRC_STORE : ASRC_READ; // R19
        ASRC_STORE: if (tmr_done) state_q <= ASRC_TRAIL; // R3
        ASRC_TRAIL: if (tmr_done) state_q <= ASRC_IDLE; // R9
        ASRC_READ:  if (tmr_done) state_q <= ASRC_FLOAT; // R13
        ASRC_FLOAT: if (tmr_done) state_q <= ASRC_IDLE; // R17
        default:    state_q <= ASRC_IDLE;
      endcase
    end
  end

  // address and input bit latched while every strobe is high
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      word_address_o <= '0;
      data_in_o      <= 1'b0;
      is_write_q     <= 1'b0;
    end else if (taking(state_q, req_i)) begin
      word_address_o <= req_addr_i; // R4 R5
      data_in_o      <= req_data_i; // R12
      is_write_q     <= req_write_i;
    end
  end

  // next strobe levels; in a write select and store fall and rise together, so the store
  // window is the select window and the memory output stays floating
  always_comb begin
    select_n_d = !(opens(state_q, tmr_done) ||
                   holds(state_q, tmr_done, ASRC_STORE) ||
                   holds(state_q, tmr_done, ASRC_READ)); // R1 R2 R10 R11
    store_n_d  = !((opens(state_q, tmr_done) && is_write_q) ||
                   holds(state_q, tmr_done, ASRC_STORE)); // R7 R2 R3
    // gate stays high during writes so the memory never drives against us
    gate_n_d   = !((opens(state_q, tmr_done) && !is_write_q) ||
                   holds(state_q, tmr_done, ASRC_READ)); // R6 R14
    done_d     = last_cycle(state_q, tmr_done);
    busy_d     = taking(state_q, req_i) ||
                 ((state_q != ASRC_IDLE) && !last_cycle(state_q, tmr_done));
  end

  // strobes leave flip-flops directly so no decode glitch reaches the memory pins
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      select_n_o <= 1'b1;
      store_n_o  <= 1'b1;
      gate_n_o   <= 1'b1;
    end else begin
      select_n_o <= select_n_d;
      store_n_o  <= store_n_d;
      gate_n_o   <= gate_n_d;
    end
  end

  // read bit taken on the last strobed cycle, a full 40 ns after select and gate
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rd_data_o <= 1'b0;
    end else if (state_q == ASRC_READ && tmr_done) begin
      rd_data_o <= data_out_i; // R13 R14 R15 R16
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= done_d; // R9
      busy_o <= busy_d;
    end
  end
endmodule
`default_nettype wire

// [asrc_host_sva.sv]
// concurrent checks on the host controller's memory pins
`timescale 1ns/100ps
`default_nettype none
module asrc_host_chk #(parameter int ADDR_W = 22) (
  input wire logic              mclk_i,
  input wire logic              nrst_i,
  input wire logic              done_o,
  input wire logic [ADDR_W-1:0] word_address_o,
  input wire logic              data_in_o,
  input wire logic              select_n_o,
  input wire logic              gate_n_o,
  input wire logic              store_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence end_s;
    (select_n_o && store_n_o && gate_n_o) ##1 done_o;
  endsequence
  chk_addr_move: assert property ($changed(word_address_o) |-> store_n_o || select_n_o)
    else $error("address moved in store");
  chk_addr_lead: assert property ($fell(select_n_o) |-> $stable(word_address_o))
    else $error("address late");
  chk_addr_hold: assert property ($rose(store_n_o) |-> $stable(word_address_o))
    else $error("address moved at end");
  chk_data_lead: assert property (!store_n_o || $rose(store_n_o) |-> $stable(data_in_o))
    else $error("data moved in store");
  chk_select_cover: assert property (!store_n_o |-> !select_n_o)
    else $error("store without select");
  chk_gate_write: assert property (!store_n_o |-> gate_n_o)
    else $error("gate low in store");
  chk_store_end: assert property ($fell(store_n_o) |-> ##1 end_s)
    else $error("store length wrong");
  chk_read_end: assert property ($fell(gate_n_o) |-> (!select_n_o && store_n_o) ##1 end_s)
    else $error("read strobes wrong");
endmodule
bind asrc_host asrc_host_chk #(.ADDR_W(ADDR_W)) asrc_host_chk_i (.mclk_i, .nrst_i, .done_o,
  .word_address_o, .data_in_o, .select_n_o, .gate_n_o, .store_n_o);
`default_nettype wire

// [asrc_sram_model.sv]
// behavioural 4M x 1 static memory answering at its slowest legal time
`timescale 1ns/100ps
`default_nettype none
module asrc_sram_model #(parameter int ACC_NS = 10) (
  input  wire logic        select_n_i,
  input  wire logic        gate_n_i,
  input  wire logic        store_n_i,
  input  wire logic [21:0] word_address_i,
  input  wire logic        data_in_i,
  output logic             data_out_o
);
  bit mem[int];
  bit wr_q;
  initial data_out_o = 1'b0;
  always @(select_n_i or store_n_i) begin
    if (wr_q && (select_n_i || store_n_i)) mem[word_address_i] = data_in_i;
    wr_q = !select_n_i && !store_n_i;
  end
  // a released pin flips rather than keeping a friendly last level
  always @(select_n_i or gate_n_i or store_n_i or word_address_i) begin
    if (!select_n_i && !gate_n_i && store_n_i) data_out_o <= #(ACC_NS) mem[word_address_i];
    else data_out_o <= #5 ~data_out_o;
  end
endmodule
`default_nettype wire

// [asrc_host_test.sv]
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
`default_nettype none
`include "asrc_params.svh"
module asrc_host_test;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0;
  logic        req_data_i = 1'b0, busy_o, done_o, rd_data_o, data_in_o, data_out_i;
  logic        select_n_o, gate_n_o, store_n_o;
  logic [21:0] req_addr_i = 22'h00_0000, word_address_o;
  int          error_cnt = 0, tests_run = 0;
  always #20 mclk_i = ~mclk_i;
  asrc_host asrc_host_i (.mclk_i, .nrst_i, .req_i, .req_write_i, .req_addr_i, .req_data_i,
    .busy_o, .done_o, .rd_data_o, .word_address_o, .data_in_o, .data_out_i, .select_n_o,
    .gate_n_o, .store_n_o);
  asrc_sram_model asrc_sram_model_i (.select_n_i(select_n_o), .gate_n_i(gate_n_o),
    .store_n_i(store_n_o), .word_address_i(word_address_o), .data_in_i(data_in_o),
    .data_out_o(data_out_i));
  task automatic results;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic go(input logic w, input logic [21:0] a, input logic d);
    @(posedge mclk_i) #1;
    {req_i, req_write_i, req_addr_i, req_data_i} = {1'b1, w, a, d};
    @(posedge mclk_i) #1;
  endtask
  task automatic acc(input logic w, input logic [21:0] a, input logic d, input logic exp);
    int n;
    int exp_n;
    exp_n = w ? `ASRC_SETUP_CYC + `ASRC_STORE_CYC + `ASRC_TRAIL_CYC
              : `ASRC_SETUP_CYC + `ASRC_READ_CYC + `ASRC_FLOAT_CYC;
    go(w, a, d);
    req_i = 1'b0;
    for (n = 0; n < 20 && done_o !== 1'b1; n++) @(posedge mclk_i) #1;
    tests_run++;
    if (n != exp_n || (!w && rd_data_o !== exp)) begin
      error_cnt++;
      $display("BAD %0t access %h read %b in %0d", $time, a, rd_data_o, n);
    end
  endtask
  task automatic t_store;
    acc(1'b1, 22'h00_0000, 1'b0, 1'b0);
    acc(1'b1, 22'h00_0000, 1'b1, 1'b0);
    acc(1'b1, 22'h3F_FFFF, 1'b0, 1'b0);
    acc(1'b1, 22'h15_5555, 1'b1, 1'b0);
    acc(1'b0, 22'h00_0000, 1'b0, 1'b1);
    acc(1'b0, 22'h3F_FFFF, 1'b0, 1'b0);
    acc(1'b0, 22'h15_5555, 1'b0, 1'b1);
    $display("t_store finished");
  endtask
  task automatic t_refuse;
    go(1'b0, 22'h00_0000, 1'b0);
    req_write_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 req_i = 1'b0;
    tests_run++;
    if (done_o !== 1'b1 || rd_data_o !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t held request disturbed a read", $time);
    end
    @(posedge mclk_i) #1;
    tests_run++;
    if (busy_o !== 1'b0 || select_n_o !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t request held while busy was queued", $time);
    end
    acc(1'b0, 22'h00_0000, 1'b0, 1'b1);
    $display("t_refuse finished");
  endtask
  task automatic t_reset;
    go(1'b1, 22'h00_0000, 1'b0);
    {req_i, nrst_i} = 2'b00;
    @(posedge mclk_i) #1;
    nrst_i = 1'b1;
    tests_run++;
    if (busy_o !== 1'b0 || store_n_o !== 1'b1 || select_n_o !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t strobes not idle after reset", $time);
    end
    acc(1'b0, 22'h00_0000, 1'b0, 1'b1);
    $display("t_reset finished");
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    t_store;
    t_refuse;
    t_reset;
    results;
  end
  // about sixty cycles of traffic, so 20 us means a hang
  initial begin
    #20us;
    error_cnt++;
    results;
  end
endmodule
`default_nettype wire
